// [src/fdc_bcd_counter.sv]
// multi-decade bcd counter with load; top decade may preset to a value
// assumes count pulses are synchronous single-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module fdc_bcd_counter #(
  parameter int unsigned DIGITS = 7
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  load,
  input  wire logic [DIGITS*4-1:0]   load_value,
  input  wire logic                  inc,
  output logic      [DIGITS*4-1:0]   value
);
  logic [DIGITS*4-1:0] value_ff;
  logic [DIGITS*4-1:0] nxt_value;
  logic                carry;

  always_comb begin
    nxt_value = value_ff;
    carry     = inc;
    if (load) begin
      nxt_value = load_value;
    end else begin
      for (int i = 0; i < DIGITS; i++) begin
        if (carry) begin
          if (value_ff[i*4 +: 4] == fdc_pkg::DIGIT_MAX) begin
            nxt_value[i*4 +: 4] = 4'h0;
          end else begin
            nxt_value[i*4 +: 4] = value_ff[i*4 +: 4] + 4'h1;
            carry = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      value_ff <= '0;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value = value_ff;
endmodule // fdc_bcd_counter
`default_nettype wire

// [src/fdc_pkg.sv]
// package for the gated decimal frequency display counter
// assumes a single 10 MHz reference clock drives all logic
package fdc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned REF_HZ        = 10000000;
  localparam int unsigned GATE_HZ       = 5;
  localparam int unsigned GATE_MS       = 100;
  localparam int unsigned LATCH_MS      = 200;
  localparam int unsigned GATE_CYCLES   = REF_HZ / 1000 * GATE_MS;
  localparam int unsigned PERIOD_CYCLES = REF_HZ / GATE_HZ;
  localparam int unsigned LATCH_CYCLES  = REF_HZ / 1000 * LATCH_MS;

  // ****************************************
  // digits
  // ****************************************
  localparam int unsigned COUNT_DIGITS = 7;
  localparam int unsigned SHOW_DIGITS  = 6;
  localparam logic [3:0]  TOP_PRESET   = 4'h9;
  localparam logic [3:0]  DIGIT_MAX    = 4'h9;

  typedef enum logic [1:0] {
    FDC_PREP,
    FDC_COUNT,
    FDC_SETTLE,
    FDC_WAIT
  } fdc_phase_type;

  typedef struct packed {
    logic [SHOW_DIGITS*4-1:0] bcd;
    logic [6:0]               seg;
    logic [SHOW_DIGITS-1:0]   digit_sel;
  } fdc_disp_type;

endpackage

// [src/fdc_top.sv]
// gated frequency display counter: heterodyne and preset counters,
// display latch, digit multiplexer and seven-segment decoder
// assumes oscillator inputs are shaped and synchronous to clk
//
// Notes on behaviour
// R1 - reference divided to 5 Hz frame; gate open exactly 0.1 s each frame
// R2 - count in 10 Hz units; lowest counted digit dropped from display
// R3 - latch takes a new result every 0.2 s, holding in between
// R4 - synthesis mode: heterodyne reset sets top decade to 9, others 0
// R5 - result shown as six decimal digits held between updates
// R6 - counter mode routes external count input into heterodyne counter
// R7 - counter mode still resolves 100 Hz on display
// R8 - two counters combined give heterodyne minus variable plus carrier
// R9 - heterodyne pulses counted only while gate open
// R10 - preset counter loads heterodyne result, adds mixed pulses in gate
// R11 - counter mode: zero reset, mixed pulses blocked, preset passes
// R12 - result goes latch, digit multiplexer, seven-segment decoder
// R13 - counters preset before gate; latch after gate and preset settle
`timescale 1ns/1ps
`default_nettype none
module fdc_top #(
  parameter int unsigned PERIOD_CYCLES = fdc_pkg::PERIOD_CYCLES,
  parameter int unsigned GATE_CYCLES   = fdc_pkg::GATE_CYCLES,
  parameter int unsigned SCAN_CYCLES   = 16
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          heterodyne_input,
  input  wire logic          count_input,
  input  wire logic          mixed_input,
  input  wire logic          counter_mode,
  output fdc_pkg::fdc_disp_type disp,
  output logic               gate_open
);
  localparam int unsigned CW = fdc_pkg::COUNT_DIGITS * 4;
  localparam int unsigned SW = fdc_pkg::SHOW_DIGITS * 4;

  // ****************************************
  // gate timing
  // ****************************************
  fdc_pkg::fdc_phase_type phase_ff, nxt_phase;
  logic [23:0]            tick_ff, nxt_tick;
  logic                   mode_ff, nxt_mode;
  logic                   in_d_ff, mix_d_ff;
  logic                   het_pulse, mix_pulse;
  logic                   sel_input;
  logic                   het_load, pre_load;
  logic [CW-1:0]          het_val, pre_val, het_init;
  logic [SW-1:0]          latch_ff, nxt_latch;

  // one frame of PERIOD_CYCLES (5 Hz), latch once per frame (0.2 s)
  always_comb begin
    nxt_phase = phase_ff;
    nxt_tick  = tick_ff + 24'h1;
    nxt_mode  = mode_ff;
    nxt_latch = latch_ff;
    het_load  = 1'b0;
    pre_load  = 1'b0;
    if (tick_ff == 24'(PERIOD_CYCLES - 1)) begin
      nxt_tick = '0;
    end
    unique case (phase_ff)
      fdc_pkg::FDC_PREP: begin
        het_load  = 1'b1; // see R13
        nxt_mode  = counter_mode; // mode frozen per frame
        nxt_phase = fdc_pkg::FDC_COUNT;
        nxt_tick  = '0;
      end
      fdc_pkg::FDC_COUNT: begin
        if (tick_ff == 24'(GATE_CYCLES - 1)) begin // see R1
          nxt_phase = fdc_pkg::FDC_SETTLE;
        end
      end
      fdc_pkg::FDC_SETTLE: begin
        pre_load  = 1'b1; // see R10
        nxt_phase = fdc_pkg::FDC_WAIT;
      end
      fdc_pkg::FDC_WAIT: begin
        // drop 10 Hz digit, hold between frames
        nxt_latch = pre_val[CW-1:4]; // see R2 R3 R13
        // prep takes the last tick, so a frame is exactly PERIOD_CYCLES
        if (tick_ff == 24'(PERIOD_CYCLES - 2)) begin // see R1 R3
          nxt_phase = fdc_pkg::FDC_PREP;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_ff <= fdc_pkg::FDC_PREP;
      tick_ff  <= '0;
      mode_ff  <= 1'b0;
      latch_ff <= '0;
      in_d_ff  <= 1'b0;
      mix_d_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      tick_ff  <= nxt_tick;
      mode_ff  <= nxt_mode;
      latch_ff <= nxt_latch;
      in_d_ff  <= sel_input;
      mix_d_ff <= mixed_input;
    end
  end

  assign gate_open = (phase_ff == fdc_pkg::FDC_COUNT);

  a_gate_length: assert property (@(posedge clk) disable iff (reset) // see R1
    $rose(gate_open) |-> gate_open [*8])
    else $error("gate shorter than expected");
  a_latch_hold: assert property (@(posedge clk) disable iff (reset) // see R3
    phase_ff != fdc_pkg::FDC_WAIT |=> $stable(latch_ff))
    else $error("latch changed outside update window");
  a_latch_drop: assert property (@(posedge clk) disable iff (reset) // see R2
    phase_ff == fdc_pkg::FDC_WAIT |=> latch_ff == $past(pre_val[CW-1:4]))
    else $error("latch not taken from preset result");

  // ****************************************
  // counters
  // ****************************************
  // rising edges; inputs must stay below half the reference rate
  assign sel_input = mode_ff ? count_input : heterodyne_input; // see R6
  assign het_pulse = gate_open && sel_input && !in_d_ff; // see R9
  // mixed pulses blocked in counter mode
  assign mix_pulse = gate_open && !mode_ff && mixed_input
                     && !mix_d_ff; // see R11 R8
  // top decade set to nine in synthesis, zero in counter mode
  // load is in prep: follow the mode frozen now, not last frame's
  assign het_init = nxt_mode ? '0
                    : {fdc_pkg::TOP_PRESET, {(CW-4){1'b0}}}; // see R4 R11

  fdc_bcd_counter #(.DIGITS(fdc_pkg::COUNT_DIGITS)) u_het (
    .clk        (clk),
    .reset      (reset),
    .load       (het_load),
    .load_value (het_init),
    .inc        (het_pulse),
    .value      (het_val)
  );

  a_count_gated: assert property (@(posedge clk) disable iff (reset) // see R9
    !gate_open |=> $stable(het_val) || $past(het_load))
    else $error("heterodyne count moved outside gate");
  a_nine_preset: assert property (@(posedge clk) disable iff (reset) // see R4
    het_load |=> mode_ff
                 || (het_val[CW-1 -: 4] == 4'h9 && het_val[CW-5:0] == '0))
    else $error("top decade not preset to nine");
  a_zero_preset: assert property (@(posedge clk) disable iff (reset) // see R11
    het_load |=> !mode_ff || het_val == '0)
    else $error("counter mode reset not zero");

  // preset counter: mixed tally cleared in prep, counts mixed pulses
  // in the same gate; sum loaded after the gate keeps
  // the sum exact since heterodyne result must be final first
  logic [CW-1:0] mix_val;
  logic [CW-1:0] sum_bcd;
  fdc_bcd_counter #(.DIGITS(fdc_pkg::COUNT_DIGITS)) u_mix (
    .clk        (clk),
    .reset      (reset),
    .load       (het_load),
    .load_value ('0),
    .inc        (mix_pulse),
    .value      (mix_val)
  );

  a_mix_blocked: assert property (@(posedge clk) disable iff (reset) // see R11
    mode_ff |-> mix_val == '0)
    else $error("mixed pulse counted in counter mode");

  // bcd add, top carry wraps (drops the 100 MHz overflow of the 9 preset)
  always_comb begin
    logic [4:0] s;
    logic       c;
    s = '0;
    c = 1'b0;
    sum_bcd = '0;
    for (int i = 0; i < fdc_pkg::COUNT_DIGITS; i++) begin
      s = {1'b0, het_val[i*4 +: 4]} + {1'b0, mix_val[i*4 +: 4]} + {4'h0, c};
      c = (s > 5'h09);
      sum_bcd[i*4 +: 4] = c ? 4'(s - 5'h0A) : s[3:0];
    end
  end

  logic [CW-1:0] pre_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_ff <= '0;
    end else if (pre_load) begin
      pre_ff <= sum_bcd; // see R8 R10
    end
  end
  assign pre_val = pre_ff;

  a_sum_load: assert property (@(posedge clk) disable iff (reset) // see R10
    pre_load |=> pre_val == $past(sum_bcd))
    else $error("preset counter not loaded with sum");
  a_preset_pass: assert property (@(posedge clk) disable iff (reset) // see R11
    pre_load && mode_ff |=> pre_val == $past(het_val))
    else $error("counter mode result not passed straight through");

  // ****************************************
  // display scan
  // ****************************************
  logic [15:0] scan_ff, nxt_scan;
  logic [2:0]  dig_ff, nxt_dig;
  fdc_pkg::fdc_disp_type disp_ff, nxt_disp;

  always_comb begin
    logic [3:0] d;
    d        = latch_ff[dig_ff*4 +: 4];
    nxt_scan = scan_ff + 16'h1;
    nxt_dig  = dig_ff;
    if (scan_ff == 16'(SCAN_CYCLES - 1)) begin
      nxt_scan = '0;
      nxt_dig  = (dig_ff == 3'(fdc_pkg::SHOW_DIGITS - 1)) ? 3'h0
                 : dig_ff + 3'h1;
    end
    nxt_disp.bcd       = latch_ff; // see R5 R7
    nxt_disp.digit_sel = '0;
    nxt_disp.digit_sel[dig_ff] = 1'b1; // see R12
    unique case (d)
      4'h0: nxt_disp.seg = 7'h3F;
      4'h1: nxt_disp.seg = 7'h06;
      4'h2: nxt_disp.seg = 7'h5B;
      4'h3: nxt_disp.seg = 7'h4F;
      4'h4: nxt_disp.seg = 7'h66;
      4'h5: nxt_disp.seg = 7'h6D;
      4'h6: nxt_disp.seg = 7'h7D;
      4'h7: nxt_disp.seg = 7'h07;
      4'h8: nxt_disp.seg = 7'h7F;
      4'h9: nxt_disp.seg = 7'h6F;
      default: nxt_disp.seg = 7'h00;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scan_ff <= '0;
      dig_ff  <= '0;
      disp_ff <= '0;
    end else begin
      scan_ff <= nxt_scan;
      dig_ff  <= nxt_dig;
      disp_ff <= nxt_disp;
    end
  end
  assign disp = disp_ff;
endmodule // fdc_top
`default_nettype wire

// [tb/fdc_osc_model.sv]
// oscillator model: pulse trains for the three counter inputs
// assumes gate_open from the counter; changes land on falling edges
`timescale 1ns/1ps
`default_nettype none
module fdc_osc_model (
  input  wire logic       clk,
  input  wire logic       gate_open,
  input  wire logic       counter_mode,
  input  wire logic [7:0] n_main,
  input  wire logic [7:0] n_side,
  output logic            heterodyne_input,
  output logic            count_input,
  output logic            mixed_input
);
  // ****************************************
  // pulse trains
  // ****************************************
  int   in_cnt  = 0;
  int   out_cnt = 0;
  logic main_p;
  logic side_p;
  logic noise;

  always @(negedge clk) begin
    in_cnt  <= gate_open ? in_cnt + 1 : 0;
    out_cnt <= gate_open ? 0 : out_cnt + 1;
  end

  // pulses kept clear of gate edges, where counting is undefined
  assign main_p = in_cnt >= 2 && in_cnt < 2 + 2 * n_main && in_cnt[0];
  assign side_p = in_cnt >= 2 && in_cnt < 2 + 2 * n_side && in_cnt[0];
  // edges while the gate is shut must be ignored
  assign noise  = out_cnt >= 4 && out_cnt < 40 && out_cnt[1];

  assign heterodyne_input = (counter_mode ? side_p : main_p) | noise;
  assign count_input      = (counter_mode ? main_p : side_p) | noise;
  assign mixed_input      = side_p | noise;
endmodule // fdc_osc_model
`default_nettype wire

// [tb/frequency_display_counter_bench.sv]
// self-checking bench for the frequency display counter
// assumes fdc_pkg, fdc_top and fdc_osc_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module frequency_display_counter_bench;
  localparam int unsigned PER  = 1000;
  localparam int unsigned GATE = 400;
  logic                  clk          = 1'b0;
  logic                  reset        = 1'b1;
  logic                  counter_mode = 1'b0;
  logic [7:0]            n_main       = 8'h00;
  logic [7:0]            n_side       = 8'h00;
  logic                  heterodyne_input;
  logic                  count_input;
  logic                  mixed_input;
  logic                  gate_open;
  fdc_pkg::fdc_disp_type disp;
  logic [23:0]           expq[$];
  logic [23:0]           held         = 24'h000000;
  int                    n_errors     = 0;
  int                    check_count  = 0;
  int                    cycles       = 0;
  int                    gate_len     = 0;
  int                    tno          = 0;
  int                    last_rise    = 0;
  logic [6:0]            exp_seg      = 7'h00;
  // gfedcba codes of the decimal digits
  localparam logic [6:0] SEGS [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
                                      7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
  int                    seed         = 32'hA147;

  always #10 clk = ~clk;

  // short frame keeps the run small; expectations scale with it
  fdc_top #(.PERIOD_CYCLES(PER), .GATE_CYCLES(GATE)) fdc_top_inst (
    .clk(clk), .reset(reset), .heterodyne_input(heterodyne_input),
    .count_input(count_input), .mixed_input(mixed_input),
    .counter_mode(counter_mode), .disp(disp), .gate_open(gate_open));

  fdc_osc_model fdc_osc_model_inst (
    .clk(clk), .gate_open(gate_open), .counter_mode(counter_mode),
    .n_main(n_main), .n_side(n_side),
    .heterodyne_input(heterodyne_input), .count_input(count_input),
    .mixed_input(mixed_input));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [23:0] expect_bcd(input logic m, input int a,
                                             input int b);
    int v;
    v = m ? a : (9000000 + a + b) % 10000000;
    v = v / 10;
    for (int i = 0; i < 6; i++) begin
      expect_bcd[i*4 +: 4] = 4'(v % 10);
      v = v / 10;
    end
  endfunction

  task automatic frame(input logic m, input int a, input int b);
    counter_mode = m;
    n_main = 8'(a);
    n_side = 8'(b);
    expq.push_back(expect_bcd(m, a, b));
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************
  // watchers
  // ****************************************
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin : watch
    forever begin
      @(posedge gate_open);
      @(negedge clk);
      check("held bcd", disp.bcd, held);
      if (tno > 0) begin
        check("frame length", 24'(cycles - last_rise), 24'(PER));
      end
      last_rise = cycles;
      gate_len = 0;
      while (gate_open === 1'b1) begin
        gate_len++;
        @(negedge clk);
      end
      check("gate length", 24'(gate_len), 24'(GATE));
      check("bcd before latch", disp.bcd, held);
      repeat (10) @(negedge clk);
      held = expq.pop_front();
      check("shown bcd", disp.bcd, held);
      check("digit select", 24'($onehot(disp.digit_sel)), 24'h000001);
      exp_seg = 7'h00;
      for (int j = 0; j < 6; j++) begin
        if (disp.digit_sel[j]) begin
          exp_seg = SEGS[held[j*4 +: 4]];
        end
      end
      check("segments", 24'(disp.seg), 24'(exp_seg));
      $display("test %0d done", tno);
      tno++;
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin : main
    frame(1'b0, 0, 0);
    repeat (8) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(negedge gate_open);
      @(negedge clk);
      case (i)
        0: frame(1'b0, 190, 190);
        1: frame(1'b1, 190, 50);
        2: frame(1'b1, 9, 190);
        default: frame(i[0], $unsigned($random(seed)) % 191,
                       $unsigned($random(seed)) % 191);
      endcase
    end
    @(negedge gate_open);
    repeat (12) @(negedge clk);
    print_verdict();
  end
endmodule // frequency_display_counter_bench
`default_nettype wire
